/* File: rtl/tc0_timer.sv */
// 8-bit timer/counter core: clock select, counter, two compare units
//
// What this block does
// - clock select 1 counts on every system clock.
// - prescaler taps /8, /64, /256, /1024; external clock never prescaled.
// - prescaler runs freely, so first prescaled count comes 1 to N clocks later.
// - prescaler reset input restarts the prescaler phase.
// - external pin sampled every clock, then fed to an edge detector.
// - select 7 counts rising pin edges, select 6 falling edges.
// - pin edge reaches the counter after 2 to 3 clocks.
// - select 0 stops counting; counter still readable and writable.
// - counter write beats any clear, increment or decrement.
// - wave mode is two low bits from control A plus high bit from B.
// - counter equal to compare sets that flag at the next timer tick.
// - flag clears on interrupt service or on writing one to it.
// - compare values double buffered in PWM modes, direct in normal and CTC.
// - compare writes hit the buffer when buffering, else the live value.
// - force strobe in non-PWM modes acts like a match, no flag, no clear.
// - counter write blocks flag and output matches at the next timer tick, even stopped; the mode 2 counter clear is not blocked.
// - reset clears compare output states; mode changes leave them alone.
// - nonzero output action hands the compare output state to the pin value.
// - output action 0 never changes the compare output state.
// - output action is unbuffered and applies from the next match.
// - mode 0 counts up, wraps ff to 00, sets overflow on reaching zero.
// - mode 2 clears the counter on a match with compare A.
// - modes 3 and 7 count single slope to top ff or compare A.
`timescale 1ns/1ps
module tc0_timer (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic [2:0] clk_source_sel,
    input  wire logic       wave_mode_bit_lo,
    input  wire logic       wave_mode_bit_mid,
    input  wire logic       wave_mode_bit_hi,
    input  wire logic [1:0] cmp_out_action_a,
    input  wire logic [1:0] cmp_out_action_b,
    input  wire logic       force_match_strobe_a,
    input  wire logic       force_match_strobe_b,
    input  wire logic       prescaler_reset,
    input  wire logic       ext_count_pin,
    input  wire logic       count_wr_en,
    input  wire logic [7:0] count_wr_data,
    input  wire logic       cmp_wr_en_a,
    input  wire logic       cmp_wr_en_b,
    input  wire logic [7:0] cmp_wr_data,
    input  wire logic [2:0] flag_clr_ones,
    input  wire logic [2:0] irq_serviced,
    input  wire logic       cmp_pin_dir_bit_a,
    input  wire logic       cmp_pin_dir_bit_b,
    input  wire logic       port_data_bit_a,
    input  wire logic       port_data_bit_b,
    output logic [7:0]      count_value,
    output logic [7:0]      compare_value_a,
    output logic [7:0]      compare_value_b,
    output logic            match_flag_a,
    output logic            match_flag_b,
    output logic            overflow_flag,
    output logic            cmp_out_state_a,
    output logic            cmp_out_state_b,
    output logic            pin_out_a,
    output logic            pin_out_b,
    output logic            pin_oe_a,
    output logic            pin_oe_b
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       down;
        logic [7:0] ocr_a;
        logic [7:0] ocr_b;
        logic [7:0] buf_a;
        logic [7:0] buf_b;
        logic       flag_a;
        logic       flag_b;
        logic       ovf;
        logic       oc_a;
        logic       oc_b;
        logic       block;
        logic       pin_a;
        logic       pin_b;
        logic       oe_a;
        logic       oe_b;
    } tc0_state_t;

    tc0_state_t s_reg;
    tc0_state_t s_next;
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic       t8;
    logic       t64;
    logic       t256;
    logic       t1024;
    logic       ext_rise;
    logic       ext_fall;
    logic       timer_tick;
    logic [2:0] wave_mode;
    logic       is_fast;
    logic       is_pc;
    logic       is_pwm;
    logic [7:0] top_val;
    logic       at_top;
    logic       hit_a;
    logic       hit_b;
    logic       wrap;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    tc0_prescaler u_pre (
        .clk         (ref_clk),
        .rst_n       (rst_n),
        .pre_reset   (prescaler_reset),
        .tap_div8    (t8),
        .tap_div64   (t64),
        .tap_div256  (t256),
        .tap_div1024 (t1024)
    );

    tc0_ext_edge u_edge (
        .clk           (ref_clk),
        .rst_n         (rst_n),
        .ext_count_pin (ext_count_pin),
        .rise_pulse    (ext_rise),
        .fall_pulse    (ext_fall)
    );

    // timer_tick: one-cycle enable that advances the counter
    always_comb
    begin
        case (clk_source_sel)
            tc0_pkg::CS_STOP:     timer_tick = 1'b0;
            tc0_pkg::CS_DIRECT:   timer_tick = 1'b1;
            tc0_pkg::CS_DIV8:     timer_tick = t8;
            tc0_pkg::CS_DIV64:    timer_tick = t64;
            tc0_pkg::CS_DIV256:   timer_tick = t256;
            tc0_pkg::CS_DIV1024:  timer_tick = t1024;
            tc0_pkg::CS_EXT_FALL: timer_tick = ext_fall;
            tc0_pkg::CS_EXT_RISE: timer_tick = ext_rise;
            default:              timer_tick = 1'b0;
        endcase
    end

    assign wave_mode = {wave_mode_bit_hi, wave_mode_bit_mid, wave_mode_bit_lo};
    assign is_fast   = (wave_mode == tc0_pkg::WM_FAST_MAX) ||
                       (wave_mode == tc0_pkg::WM_FAST_OCRA);
    assign is_pc     = (wave_mode == tc0_pkg::WM_PC_MAX) ||
                       (wave_mode == tc0_pkg::WM_PC_OCRA);
    assign is_pwm    = is_fast || is_pc;
    assign top_val   = wave_mode[2] ? s_reg.ocr_a : tc0_pkg::CNT_MAX;
    assign at_top    = (s_reg.cnt == top_val);
    assign hit_a     = timer_tick && !s_reg.block && (s_reg.cnt == s_reg.ocr_a);
    assign hit_b     = timer_tick && !s_reg.block && (s_reg.cnt == s_reg.ocr_b);
    assign wrap      = timer_tick && is_fast && at_top;

    // new output state for one unit on a match (or forced match)
    function automatic logic oc_on_match(input logic [1:0] act, input logic cur,
                                         input logic fast, input logic pc,
                                         input logic down, input logic tog_ok);
        logic nv;
        nv = cur;
        if (fast || pc)
        begin
            // pc: up-count match acts as clear for action 2, down-count inverts
            if (act == tc0_pkg::COM_CLEAR)
                nv = pc && down;
            else if (act == tc0_pkg::COM_SET)
                nv = !(pc && down);
            else if (act == tc0_pkg::COM_TOGGLE && tog_ok)
                nv = !cur;
        end
        else
        begin
            case (act)
                tc0_pkg::COM_TOGGLE: nv = !cur;
                tc0_pkg::COM_CLEAR:  nv = 1'b0;
                tc0_pkg::COM_SET:    nv = 1'b1;
                default:             nv = cur;
            endcase
        end
        return nv;
    endfunction

    always_comb
    begin
        s_next = s_reg;

        // counter unit
        if (count_wr_en)
        begin
            s_next.cnt   = count_wr_data;
            s_next.block = 1'b1;
        end
        else if (timer_tick)
        begin
            s_next.block = 1'b0;
            case (wave_mode)
                tc0_pkg::WM_CTC:
                    s_next.cnt = hit_a || (s_reg.cnt == s_reg.ocr_a) ?
                                 tc0_pkg::CNT_BOTTOM : s_reg.cnt + 8'h01;
                tc0_pkg::WM_FAST_MAX, tc0_pkg::WM_FAST_OCRA:
                    s_next.cnt = at_top ? tc0_pkg::CNT_BOTTOM : s_reg.cnt + 8'h01;
                tc0_pkg::WM_PC_MAX, tc0_pkg::WM_PC_OCRA:
                begin
                    if (!s_reg.down && at_top)
                        s_next.down = 1'b1;
                    else if (s_reg.down && s_reg.cnt == tc0_pkg::CNT_BOTTOM)
                        s_next.down = 1'b0;
                    s_next.cnt = s_next.down ? s_reg.cnt - 8'h01 : s_reg.cnt + 8'h01;
                end
                default:
                    s_next.cnt = s_reg.cnt + 8'h01;
            endcase
        end
        if (!is_pc)
            s_next.down = 1'b0;

        // overflow flag; set beats any clear of the same cycle
        if (flag_clr_ones[2] || irq_serviced[2])
            s_next.ovf = 1'b0;
        if (timer_tick && !count_wr_en)
        begin
            if (is_fast ? at_top :
                is_pc ? (s_reg.down && s_reg.cnt == 8'h01) :
                (s_reg.cnt == tc0_pkg::CNT_MAX))
                s_next.ovf = 1'b1;
        end

        // compare flags
        if (flag_clr_ones[0] || irq_serviced[0])
            s_next.flag_a = 1'b0;
        if (flag_clr_ones[1] || irq_serviced[1])
            s_next.flag_b = 1'b0;
        if (hit_a)
            s_next.flag_a = 1'b1;
        if (hit_b)
            s_next.flag_b = 1'b1;

        // compare registers: buffered in pwm modes only
        if (cmp_wr_en_a)
        begin
            s_next.buf_a = cmp_wr_data;
            if (!is_pwm)
                s_next.ocr_a = cmp_wr_data;
        end
        if (cmp_wr_en_b)
        begin
            s_next.buf_b = cmp_wr_data;
            if (!is_pwm)
                s_next.ocr_b = cmp_wr_data;
        end
        if (!is_pwm)
        begin
            // keeps the view consistent after leaving a pwm mode
            if (!cmp_wr_en_a)
                s_next.ocr_a = s_reg.buf_a;
            if (!cmp_wr_en_b)
                s_next.ocr_b = s_reg.buf_b;
        end
        else if (wrap || (timer_tick && is_pc && !s_reg.down && at_top))
        begin
            s_next.ocr_a = s_reg.buf_a;
            s_next.ocr_b = s_reg.buf_b;
        end

        // compare output states; action read live each match
        if (hit_a || (force_match_strobe_a && !is_pwm))
            s_next.oc_a = oc_on_match(cmp_out_action_a, s_reg.oc_a, is_fast, is_pc,
                                      s_reg.down, wave_mode_bit_hi);
        if (hit_b || (force_match_strobe_b && !is_pwm))
            s_next.oc_b = oc_on_match(cmp_out_action_b, s_reg.oc_b, is_fast, is_pc,
                                      s_reg.down, 1'b0);
        // fast pwm: restore level at bottom unless the wrap itself matched
        if (wrap && !hit_a && cmp_out_action_a[1])
            s_next.oc_a = !cmp_out_action_a[0];
        if (wrap && !hit_b && cmp_out_action_b[1])
            s_next.oc_b = !cmp_out_action_b[0];

        // pin override, direction stays with the port
        s_next.pin_a = (cmp_out_action_a != tc0_pkg::COM_NONE) ? s_reg.oc_a
                                                               : port_data_bit_a;
        s_next.pin_b = (cmp_out_action_b != tc0_pkg::COM_NONE) ? s_reg.oc_b
                                                               : port_data_bit_b;
        s_next.oe_a  = cmp_pin_dir_bit_a;
        s_next.oe_b  = cmp_pin_dir_bit_b;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign count_value     = s_reg.cnt;
    assign compare_value_a = s_reg.buf_a;
    assign compare_value_b = s_reg.buf_b;
    assign match_flag_a    = s_reg.flag_a;
    assign match_flag_b    = s_reg.flag_b;
    assign overflow_flag   = s_reg.ovf;
    assign cmp_out_state_a = s_reg.oc_a;
    assign cmp_out_state_b = s_reg.oc_b;
    assign pin_out_a       = s_reg.pin_a;
    assign pin_out_b       = s_reg.pin_b;
    assign pin_oe_a        = s_reg.oe_a;
    assign pin_oe_b        = s_reg.oe_b;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    direct_count_a: assert property ((clk_source_sel == tc0_pkg::CS_DIRECT && !count_wr_en
        && wave_mode == tc0_pkg::WM_NORMAL) |=> count_value == $past(count_value) + 8'h01)
        else $error("direct clock did not count");
    stop_hold_a: assert property ((clk_source_sel == tc0_pkg::CS_STOP && !count_wr_en)
        |=> $stable(count_value))
        else $error("stopped counter moved");
    wr_priority_a: assert property (count_wr_en |=> count_value == $past(count_wr_data))
        else $error("counter write lost");
    flag_set_a: assert property ((timer_tick && !s_reg.block && count_value == s_reg.ocr_a)
        |=> match_flag_a)
        else $error("match did not set flag a");
    flag_clear_a: assert property ((flag_clr_ones[0] && !hit_a) |=> !match_flag_a)
        else $error("flag a not cleared");
    match_block_a: assert property ((count_wr_en ##1 (!count_wr_en && !match_flag_a
        && !timer_tick) [*1] ##1 (timer_tick && !count_wr_en && !match_flag_a))
        |=> !match_flag_a)
        else $error("blocked match set flag");
    force_noflag_a: assert property ((force_match_strobe_a && !is_pwm && !hit_a
        && !match_flag_a) |=> !match_flag_a)
        else $error("force set a flag");
    none_hold_a: assert property ((cmp_out_action_a == tc0_pkg::COM_NONE && !wrap)
        |=> $stable(cmp_out_state_a))
        else $error("action 0 changed output");
    pin_source_a: assert property (cmp_out_action_a != tc0_pkg::COM_NONE
        |=> pin_out_a == $past(cmp_out_state_a))
        else $error("pin not driven by compare state");
    ctc_clear_a: assert property ((wave_mode == tc0_pkg::WM_CTC && hit_a && !count_wr_en)
        |=> count_value == tc0_pkg::CNT_BOTTOM)
        else $error("ctc did not clear");
endmodule

/* File: rtl/tc0_pkg.sv */
// shared constants for the timer/counter core
package tc0_pkg;
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hff;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    // clock select codes
    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIRECT   = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // waveform modes
    localparam logic [2:0] WM_NORMAL   = 3'h0;
    localparam logic [2:0] WM_PC_MAX   = 3'h1;
    localparam logic [2:0] WM_CTC      = 3'h2;
    localparam logic [2:0] WM_FAST_MAX = 3'h3;
    localparam logic [2:0] WM_PC_OCRA  = 3'h5;
    localparam logic [2:0] WM_FAST_OCRA = 3'h7;
    // compare output actions
    localparam logic [1:0] COM_NONE    = 2'h0;
    localparam logic [1:0] COM_TOGGLE  = 2'h1;
    localparam logic [1:0] COM_CLEAR   = 2'h2;
    localparam logic [1:0] COM_SET     = 2'h3;
    // prescaler: width and the tap positions for /8, /64, /256, /1024
    localparam int         PRE_W       = 10;
    localparam int         TAP_DIV8    = 3;
    localparam int         TAP_DIV64   = 6;
    localparam int         TAP_DIV256  = 8;
    localparam int         TAP_DIV1024 = 10;
    localparam logic [9:0] PRE_RST     = 10'h000;
endpackage

/* File: rtl/tc0_prescaler.sv */
// free running system clock prescaler with four tap pulses
`timescale 1ns/1ps
module tc0_prescaler (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pre_reset,
    output logic            tap_div8,
    output logic            tap_div64,
    output logic            tap_div256,
    output logic            tap_div1024
);
    typedef struct packed {
        logic [9:0] cnt;
        logic       t8;
        logic       t64;
        logic       t256;
        logic       t1024;
    } tc0_pre_t;

    tc0_pre_t s_reg;
    tc0_pre_t s_next;

    always_comb
    begin
        s_next       = s_reg;
        s_next.cnt   = pre_reset ? tc0_pkg::PRE_RST : s_reg.cnt + 10'h001;
        // runs whatever the clock select says; a reset restarts the phase
        s_next.t8    = !pre_reset && (&s_reg.cnt[tc0_pkg::TAP_DIV8-1:0]);
        s_next.t64   = !pre_reset && (&s_reg.cnt[tc0_pkg::TAP_DIV64-1:0]);
        s_next.t256  = !pre_reset && (&s_reg.cnt[tc0_pkg::TAP_DIV256-1:0]);
        s_next.t1024 = !pre_reset && (&s_reg.cnt[tc0_pkg::TAP_DIV1024-1:0]);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign tap_div8    = s_reg.t8;
    assign tap_div64   = s_reg.t64;
    assign tap_div256  = s_reg.t256;
    assign tap_div1024 = s_reg.t1024;
endmodule

/* File: rtl/tc0_ext_edge.sv */
// external count pin synchroniser and edge detector
`timescale 1ns/1ps
module tc0_ext_edge (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ext_count_pin,
    output logic            rise_pulse,
    output logic            fall_pulse
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } tc0_edge_t;

    tc0_edge_t s_reg;
    tc0_edge_t s_next;

    always_comb
    begin
        s_next      = s_reg;
        // sampled once per clock; only sync reads meta
        s_next.meta = ext_count_pin;
        s_next.sync = s_reg.meta;
        s_next.last = s_reg.sync;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign rise_pulse = s_reg.sync && !s_reg.last;
    assign fall_pulse = !s_reg.sync && s_reg.last;
endmodule

/* File: verification/tc0_ext_src.sv */
// external count source model driving the counter input pin
`timescale 1ns/1ps
module tc0_ext_src #(
    parameter int HALF = 3
) (
    input  wire logic ref_clk,
    input  wire logic run,
    output logic      pin
);
    int cnt = 0;
    initial pin = 1'b0;
    // pin only moves while running; bench stops after an even number of toggles
    always @(posedge ref_clk)
    begin
        if (!run)
            cnt <= 0;
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            pin <= ~pin;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

/* File: verification/tb_tc0_timer.sv */
// self-checking bench for the timer/counter core
`timescale 1ns/1ps
module tb_tc0_timer;
    typedef struct {logic [2:0] cs; logic ext; int n; logic [7:0] exp;} tc0_row_t;
    logic       ref_clk = 0;
    logic       arst_n  = 0;
    logic [2:0] cs      = 0;
    logic [2:0] wm      = 0;
    logic [1:0] act     = 0;
    logic       frc     = 0;
    logic       prs     = 0;
    logic       cwe     = 0;
    logic [7:0] cwd     = 0;
    logic       awe     = 0;
    logic       bwe     = 0;
    logic [7:0] awd     = 0;
    logic [2:0] fclr    = 0;
    logic [2:0] isrv    = 0;
    logic       dir     = 0;
    logic       pd      = 0;
    logic       run     = 0;
    logic       ext_pin;
    logic [7:0] cnt;
    logic [7:0] cva;
    logic [7:0] cvb;
    logic       mfa;
    logic       mfb;
    logic       ovf;
    logic       osa;
    logic       osb;
    logic       poa;
    logic       pob;
    logic       oea;
    logic       oeb;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    tc0_row_t   rows [8] = '{'{3'h1, 0, 21, 8'h14}, '{3'h2, 0, 42, 8'h05},
        '{3'h3, 0, 194, 8'h03}, '{3'h4, 0, 514, 8'h02}, '{3'h5, 0, 1026, 8'h01},
        '{3'h0, 0, 50, 8'h00}, '{3'h6, 1, 24, 8'h04}, '{3'h7, 1, 24, 8'h04}};
    logic [1:0] acts [6] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h1, 2'h1};
    logic       exps [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    tc0_ext_src src (.ref_clk(ref_clk), .run(run), .pin(ext_pin));

    tc0_timer dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_source_sel(cs),
        .wave_mode_bit_lo(wm[0]), .wave_mode_bit_mid(wm[1]), .wave_mode_bit_hi(wm[2]),
        .cmp_out_action_a(act), .cmp_out_action_b(act),
        .force_match_strobe_a(frc), .force_match_strobe_b(frc),
        .prescaler_reset(prs), .ext_count_pin(ext_pin),
        .count_wr_en(cwe), .count_wr_data(cwd), .cmp_wr_en_a(awe), .cmp_wr_en_b(bwe),
        .cmp_wr_data(awd), .flag_clr_ones(fclr), .irq_serviced(isrv),
        .cmp_pin_dir_bit_a(dir), .cmp_pin_dir_bit_b(dir),
        .port_data_bit_a(pd), .port_data_bit_b(pd),
        .count_value(cnt), .compare_value_a(cva), .compare_value_b(cvb),
        .match_flag_a(mfa), .match_flag_b(mfb), .overflow_flag(ovf),
        .cmp_out_state_a(osa), .cmp_out_state_b(osb), .pin_out_a(poa),
        .pin_out_b(pob), .pin_oe_a(oea), .pin_oe_b(oeb));

    always #20 ref_clk = ~ref_clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk1(input string what, input logic e, input logic g);
        chk8(what, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wr_cnt(input logic [7:0] d);
        cwe = 1;
        cwd = d;
        cyc(1);
        cwe = 0;
    endtask

    task automatic wr_cmp(input logic b, input logic [7:0] d);
        awe = !b;
        bwe = b;
        awd = d;
        cyc(1);
        awe = 0;
        bwe = 0;
    endtask

    task automatic tick_run(input int n);
        cs = 3'h1;
        cyc(n);
        cs = 3'h0;
        cyc(1);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ceiling well above the roughly 2000 cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_of_test();
        end
    end

    initial
    begin
        cyc(10);
        arst_n = 1;
        cyc(3);
        chk8("count", 8'h00, cnt);
        chk1("state a", 1'b0, osa);
        chk1("state b", 1'b0, osb);
        $display("reset test done");
        foreach (rows[i])
        begin
            cs = rows[i].cs;
            cwe = 1;
            cwd = 0;
            prs = 1;
            run = rows[i].ext;
            cyc(1);
            cwe = 0;
            prs = 0;
            cyc(rows[i].n - 1);
            run = 0;
            if (rows[i].ext)
                cyc(5);
            cs = 0;
            cyc(1);
            chk8("count", rows[i].exp, cnt);
        end
        $display("clock source test done");
        // both units share one compare value so flag b is exercised as well
        awe = 1;
        bwe = 1;
        awd = 8'h10;
        fclr = 3'h7;
        cyc(1);
        awe = 0;
        bwe = 0;
        fclr = 0;
        wr_cnt(8'h10);
        // one idle stopped cycle, so the block must survive until the tick
        cyc(1);
        tick_run(2);
        chk1("flag a", 1'b0, mfa);
        wr_cnt(8'h0e);
        tick_run(4);
        chk1("flag a", 1'b1, mfa);
        chk1("flag b", 1'b1, mfb);
        fclr = 3'h1;
        cyc(1);
        fclr = 0;
        chk1("flag a", 1'b0, mfa);
        chk1("flag b", 1'b1, mfb);
        wr_cnt(8'h0e);
        tick_run(4);
        chk1("flag a", 1'b1, mfa);
        isrv = 3'h1;
        cyc(1);
        isrv = 0;
        chk1("flag a", 1'b0, mfa);
        $display("match flag test done");
        dir = 1;
        pd = 1;
        wr_cmp(1, 8'h33);
        chk8("compare b", 8'h33, cvb);
        foreach (acts[i])
        begin
            act = acts[i];
            frc = 1;
            cyc(1);
            frc = 0;
            cyc(2);
            chk1("state a", exps[i], osa);
            chk1("state b", exps[i], osb);
            chk1("pin a", exps[i], poa);
            chk1("pin b", exps[i], pob);
        end
        chk1("flag a", 1'b0, mfa);
        chk8("count", 8'h12, cnt);
        chk1("drive a", 1'b1, oea);
        chk1("drive b", 1'b1, oeb);
        act = 0;
        pd = 0;
        cyc(2);
        chk1("pin a", 1'b0, poa);
        wm = 3'h3;
        cyc(2);
        chk1("state a", 1'b1, osa);
        $display("force and output test done");
        wm = 3'h2;
        wr_cmp(0, 8'h03);
        wr_cnt(8'h00);
        tick_run(6);
        chk8("count", 8'h02, cnt);
        chk1("overflow", 1'b0, ovf);
        wm = 3'h0;
        wr_cnt(8'hfe);
        tick_run(3);
        chk8("count", 8'h01, cnt);
        chk1("overflow", 1'b1, ovf);
        wm = 3'h7;
        wr_cmp(0, 8'h08);
        chk8("compare a", 8'h08, cva);
        wr_cnt(8'h00);
        tick_run(12);
        chk8("count", 8'h08, cnt);
        // phase correct with top from compare a: up to 8, then down
        wm = 3'h5;
        wr_cnt(8'h06);
        tick_run(5);
        chk8("count", 8'h05, cnt);
        $display("mode test done");
        chk1("state a", 1'b1, osa);
        arst_n = 0;
        cyc(2);
        arst_n = 1;
        cyc(3);
        chk1("state a", 1'b0, osa);
        $display("reset repeat test done");
        end_of_test();
    end
endmodule
